// ===== core/aew_wake_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - A configuration command switches the device between active and low power mode.
// - The lock flag in the output data shows that the tracking converter has locked.
// - The store-reference command copies the current angle into the retained reference.
// - Retained registers keep their settings while the main supply is off.
// - After each power-up, once 250 us have passed, the fresh angle is compared with the reference.
// - A difference above the threshold raises the wake request, otherwise wake stays released.
// - The wake threshold is written by the user settings command and used by the compare.
// - The gain control value saturates at 0 for strong fields and 63 for weak or missing fields.
// - A wake drives the open-drain line low for 10 us and then releases it.
// - Store-reference has code 00011, and without a stored reference every startup wakes.
// - Trim-reload has code 10011 and makes the trim values valid.
// - Retained storage apart from the trim-valid flag is written only while the trim values are valid and the wake-enable fuse bit is set.
module aew_wake_ctrl #(
  parameter int TON_CYCLES = aew_pkg::T_ON_CYCLES  // on-time before compare, in clock cycles
) (
  input  wire logic                         CLOCK,            // 100 MHz system clock
  input  wire logic                         RESETN,           // backup supply reset, active low
  input  wire logic                         VDD_ON,           // main supply present
  input  wire logic                         CMD_VALID,        // decoded serial command strobe
  input  wire logic [aew_pkg::CODE_W-1:0]   CMD_CODE,         // command code
  input  wire logic [aew_pkg::ANGLE_W-1:0]  CMD_DATA,         // command data byte
  input  wire logic [aew_pkg::ANGLE_W-1:0]  ANGLE_IN,         // measured angle
  input  wire logic                         CONVERTER_LOCKED, // tracking converter locked
  input  wire logic                         FIELD_STRONG,     // amplitude too high, lower gain
  input  wire logic                         FIELD_WEAK,       // amplitude too low, raise gain
  input  wire logic                         WAKE_ENABLE_OTP,  // wake-enable fuse bit
  output logic      [aew_pkg::ANGLE_W-1:0]  ANGLE_OUT,        // angle for the output stream
  output logic                              LOCK_FLAG,        // lock flag for the output stream
  output logic      [aew_pkg::GAIN_W-1:0]   GAIN_CONTROL_VALUE, // gain control value
  output logic                              LOW_POWER,        // low power mode active
  output logic                              TRIM_VALID,       // trim values loaded
  output logic                              WAKE_O,           // wake pin output level
  output logic                              WAKE_OEN          // wake pin enable, low drives
);
  import aew_pkg::*;

  localparam int CNT_MAX = (TON_CYCLES > WAKE_CYCLES) ? TON_CYCLES : WAKE_CYCLES;
  localparam int CNT_W   = $clog2(CNT_MAX + 1);
  localparam logic [CNT_W-1:0] TON_LAST  = CNT_W'(TON_CYCLES - 1);
  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);
  localparam logic [CNT_W-1:0] WAKE_LEN  = CNT_W'(WAKE_CYCLES);

  aew_ret_if ret ();

  aew_pwr_type        state;
  aew_pwr_type        next_state;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   next_cnt;
  logic               next_wake_oen;
  logic               low_power;
  logic               next_low_power;
  logic [ANGLE_W-1:0] angle;
  logic [ANGLE_W-1:0] next_angle;
  logic               lock;
  logic               next_lock;
  logic [GAIN_W-1:0]  gain;
  logic [GAIN_W-1:0]  next_gain;
  logic               cmd_ok;
  logic               storing;
  logic               wake_hit;
  logic [CNT_W-1:0]   low_len;

  aew_retain u_retain (
    .clock  (CLOCK),
    .resetn (RESETN),
    .ret    (ret)
  );

  // commands only count while the chip is powered and out of PWR_OFF, so also during settle and wake
  assign cmd_ok   = CMD_VALID && VDD_ON && (state != PWR_OFF);
  assign storing  = ret.trim_valid && WAKE_ENABLE_OTP;
  // no reference yet means every startup wakes
  assign wake_hit = WAKE_ENABLE_OTP &&
                    (!ret.ref_valid || (angle_distance(ANGLE_IN, ret.ref_angle) > ret.threshold));

  // retained storage writes
  assign ret.wr_live    = storing && VDD_ON && (state != PWR_OFF) && !low_power && CONVERTER_LOCKED;
  assign ret.live_angle = ANGLE_IN;
  assign ret.live_gain  = gain;
  assign ret.wr_ref     = storing && cmd_ok && (CMD_CODE == CMD_STORE_REF);
  assign ret.ref_data   = ANGLE_IN;
  assign ret.wr_thr     = storing && cmd_ok && (CMD_CODE == CMD_PROGRAM_USER_SETTINGS);
  assign ret.thr_data   = CMD_DATA;
  assign ret.wr_trim    = cmd_ok && (CMD_CODE == CMD_TRIM_RELOAD);

  // power-up sequencing: wait the on-time, compare once, maybe pulse wake
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_wake_oen = 1'b1;
    unique case (state)
      PWR_OFF: begin
        next_cnt = '0;
        if (VDD_ON) begin
          next_state = PWR_SETTLE;
        end
      end
      PWR_SETTLE: begin
        if (cnt == TON_LAST) begin
          next_cnt = '0;
          if (wake_hit) begin
            next_state    = PWR_WAKE;
            next_wake_oen = 1'b0;
          end else begin
            next_state = PWR_RUN;
          end
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      PWR_WAKE: begin
        if (cnt == WAKE_LAST) begin
          next_state = PWR_RUN;
        end else begin
          next_cnt      = cnt + 1'b1;
          next_wake_oen = 1'b0;
        end
      end
      PWR_RUN: begin
        next_cnt = '0;
      end
    endcase
    // supply loss cuts any pulse short: the pad has no power to hold it
    if (!VDD_ON) begin
      next_state    = PWR_OFF;
      next_cnt      = '0;
      next_wake_oen = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state    <= PWR_OFF;
      cnt      <= '0;
      WAKE_OEN <= 1'b1;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      WAKE_OEN <= next_wake_oen;
    end
  end

  // mode and measurement: angle and gain frozen and lock dropped in low power, angle and gain restored from storage at power-up
  always_comb begin
    next_low_power = low_power;
    next_angle     = angle;
    next_lock      = lock;
    next_gain      = gain;
    if (state == PWR_OFF) begin
      next_low_power = 1'b0;
      next_lock      = 1'b0;
      if (VDD_ON) begin
        next_angle = ret.saved_angle;
        next_gain  = ret.saved_gain;
      end
    end else begin
      if (cmd_ok && (CMD_CODE == CMD_WRITE_CONFIG)) begin
        next_low_power = CMD_DATA[CFG_LOW_POWER_BIT];
      end
      if (low_power) begin
        next_lock = 1'b0;
      end else begin
        next_angle = ANGLE_IN;
        next_lock  = CONVERTER_LOCKED;
        if (FIELD_WEAK && !FIELD_STRONG && (gain != GAIN_MAX)) begin
          next_gain = gain + 1'b1;
        end else if (FIELD_STRONG && !FIELD_WEAK && (gain != GAIN_MIN)) begin
          next_gain = gain - 1'b1;
        end
      end
    end
    if (!VDD_ON) begin
      next_low_power = 1'b0;
      next_lock      = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      low_power <= 1'b0;
      angle     <= ANGLE_RESET;
      lock      <= 1'b0;
      gain      <= GAIN_RESET;
    end else begin
      low_power <= next_low_power;
      angle     <= next_angle;
      lock      <= next_lock;
      gain      <= next_gain;
    end
  end

  assign ANGLE_OUT          = angle;
  assign LOCK_FLAG          = lock;
  assign GAIN_CONTROL_VALUE = gain;
  assign LOW_POWER          = low_power;
  assign TRIM_VALID         = ret.trim_valid;
  assign WAKE_O             = 1'b0;  // open drain: only ever pulls low

  // helper for checks: length of the current low phase on the wake pin
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      low_len <= '0;
    end else begin
      low_len <= WAKE_OEN ? '0 : low_len + 1'b1;
    end
  end

  property p_low_power;
    @(posedge CLOCK) disable iff (!RESETN)
      cmd_ok && (CMD_CODE == CMD_WRITE_CONFIG) |=> (LOW_POWER == $past(CMD_DATA[CFG_LOW_POWER_BIT]));
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power mode not taken from command");

  property p_lock;
    @(posedge CLOCK) disable iff (!RESETN)
      VDD_ON && (state != PWR_OFF) && !low_power ##1 VDD_ON |-> (LOCK_FLAG == $past(CONVERTER_LOCKED));
  endproperty
  a_lock: assert property (p_lock) else $error("lock flag does not follow converter");

  property p_store_ref;
    @(posedge CLOCK) disable iff (!RESETN)
      ret.wr_ref |=> ret.ref_valid && (ret.ref_angle == $past(ANGLE_IN));
  endproperty
  a_store_ref: assert property (p_store_ref) else $error("reference angle not stored");

  property p_compare_time;
    @(posedge CLOCK) disable iff (!RESETN)
      $fell(WAKE_OEN) |-> ($past(state) == PWR_SETTLE) && ($past(cnt) == TON_LAST);
  endproperty
  a_compare_time: assert property (p_compare_time) else $error("wake started outside compare point");

  property p_quiet;
    @(posedge CLOCK) disable iff (!RESETN)
      (state == PWR_SETTLE) && (cnt == TON_LAST) && VDD_ON && ret.ref_valid &&
      (angle_distance(ANGLE_IN, ret.ref_angle) <= ret.threshold) |=> WAKE_OEN ##1 WAKE_OEN;
  endproperty
  a_quiet: assert property (p_quiet) else $error("wake driven below threshold");

  property p_thr_write;
    @(posedge CLOCK) disable iff (!RESETN)
      ret.wr_thr |=> (ret.threshold == $past(CMD_DATA));
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold not stored");

  property p_gain_top;
    @(posedge CLOCK) disable iff (!RESETN)
      (GAIN_CONTROL_VALUE == GAIN_MAX) && !FIELD_STRONG && VDD_ON && (state != PWR_OFF) |=>
      (GAIN_CONTROL_VALUE == GAIN_MAX);
  endproperty
  a_gain_top: assert property (p_gain_top) else $error("gain left upper saturation");

  property p_gain_floor;
    @(posedge CLOCK) disable iff (!RESETN)
      (GAIN_CONTROL_VALUE == GAIN_MIN) && !FIELD_WEAK && VDD_ON && (state != PWR_OFF) |=>
      (GAIN_CONTROL_VALUE == GAIN_MIN);
  endproperty
  a_gain_floor: assert property (p_gain_floor) else $error("gain left lower saturation");

  property p_wake_len;
    @(posedge CLOCK) disable iff (!RESETN)
      $rose(WAKE_OEN) && VDD_ON |-> (low_len == WAKE_LEN);
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake pulse length wrong");

  property p_no_ref;
    @(posedge CLOCK) disable iff (!RESETN)
      (state == PWR_SETTLE) && (cnt == TON_LAST) && VDD_ON && WAKE_ENABLE_OTP && !ret.ref_valid |=> !WAKE_OEN;
  endproperty
  a_no_ref: assert property (p_no_ref) else $error("no wake without reference");

  property p_trim;
    @(posedge CLOCK) disable iff (!RESETN)
      ret.wr_trim |=> TRIM_VALID;
  endproperty
  a_trim: assert property (p_trim) else $error("trim reload not taken");

  // watches the stored words themselves, so a leak inside the retained block is caught too
  property p_copy_gate;
    @(posedge CLOCK) disable iff (!RESETN)
      !WAKE_ENABLE_OTP || !ret.trim_valid |=> $stable(ret.ref_angle) && $stable(ret.ref_valid) &&
      $stable(ret.threshold) && $stable(ret.saved_angle) && $stable(ret.saved_gain);
  endproperty
  a_copy_gate: assert property (p_copy_gate) else $error("storage written without wake enable");

endmodule
`default_nettype wire

// ===== shared/aew_pkg.sv
`default_nettype none
package aew_pkg;

  // data widths
  localparam int ANGLE_W = 8;
  localparam int GAIN_W  = 6;
  localparam int CODE_W  = 5;

  // serial command codes as seen on the decoded command port
  localparam logic [CODE_W-1:0] CMD_STORE_REF                 = 5'h03;
  localparam logic [CODE_W-1:0] CMD_TRIM_RELOAD               = 5'h13;
  localparam logic [CODE_W-1:0] CMD_WRITE_CONFIG              = 5'h17;
  localparam logic [CODE_W-1:0] CMD_PROGRAM_USER_SETTINGS     = 5'h0a;

  // configuration field position inside the command data byte
  localparam int CFG_LOW_POWER_BIT = 0;

  // gain control limits and reset values
  localparam logic [GAIN_W-1:0]  GAIN_MIN        = 6'h00;
  localparam logic [GAIN_W-1:0]  GAIN_MAX        = 6'h3f;
  localparam logic [GAIN_W-1:0]  GAIN_RESET      = 6'h00;
  localparam logic [ANGLE_W-1:0] ANGLE_RESET     = 8'h00;
  localparam logic [ANGLE_W-1:0] THRESHOLD_RESET = 8'h00;

  // timing: figures in their own unit, cycles derived (least times round up)
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int NS_PER_US       = 1000;
  localparam int T_ON_MIN_US     = 250;
  localparam int T_WAKE_PULSE_US = 10;
  localparam int T_ON_CYCLES     = (T_ON_MIN_US * NS_PER_US + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int WAKE_CYCLES     = (T_WAKE_PULSE_US * NS_PER_US + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // power sequencing states
  typedef enum logic [1:0] {
    PWR_OFF    = 2'b00,
    PWR_SETTLE = 2'b01,
    PWR_WAKE   = 2'b10,
    PWR_RUN    = 2'b11
  } aew_pwr_type;

  // shortest-path distance between two angles on a 256-position circle
  function automatic logic [ANGLE_W-1:0] angle_distance(input logic [ANGLE_W-1:0] a,
                                                        input logic [ANGLE_W-1:0] b);
    logic [ANGLE_W-1:0] d;
    d = a - b;
    angle_distance = d[ANGLE_W-1] ? ANGLE_W'(~d + 8'h01) : d;
  endfunction

endpackage
`default_nettype wire

// ===== shared/aew_ret_if.sv
`timescale 1ns/1ns
`default_nettype none
interface aew_ret_if;
  import aew_pkg::*;

  logic               wr_live;
  logic [ANGLE_W-1:0] live_angle;
  logic [GAIN_W-1:0]  live_gain;
  logic               wr_ref;
  logic [ANGLE_W-1:0] ref_data;
  logic               wr_thr;
  logic [ANGLE_W-1:0] thr_data;
  logic               wr_trim;
  logic [ANGLE_W-1:0] ref_angle;
  logic               ref_valid;
  logic [ANGLE_W-1:0] threshold;
  logic [ANGLE_W-1:0] saved_angle;
  logic [GAIN_W-1:0]  saved_gain;
  logic               trim_valid;

  modport ctrl  (output wr_live, live_angle, live_gain, wr_ref, ref_data, wr_thr, thr_data, wr_trim,
                 input  ref_angle, ref_valid, threshold, saved_angle, saved_gain, trim_valid);
  modport store (input  wr_live, live_angle, live_gain, wr_ref, ref_data, wr_thr, thr_data, wr_trim,
                 output ref_angle, ref_valid, threshold, saved_angle, saved_gain, trim_valid);
endinterface
`default_nettype wire

// ===== core/aew_retain.sv
`timescale 1ns/1ns
`default_nettype none
// storage kept alive by the backup supply; only the backup reset clears it
module aew_retain (
  input  wire logic clock,   // system clock
  input  wire logic resetn,  // backup supply reset, active low
  aew_ret_if.store  ret      // write strobes in, stored values out
);
  import aew_pkg::*;

  logic [ANGLE_W-1:0] next_ref_angle;
  logic               next_ref_valid;
  logic [ANGLE_W-1:0] next_threshold;
  logic [ANGLE_W-1:0] next_saved_angle;
  logic [GAIN_W-1:0]  next_saved_gain;
  logic               next_trim_valid;

  // main supply loss does not touch these, so settings survive off-time
  always_comb begin
    next_ref_angle   = ret.ref_angle;
    next_ref_valid   = ret.ref_valid;
    next_threshold   = ret.threshold;
    next_saved_angle = ret.saved_angle;
    next_saved_gain  = ret.saved_gain;
    next_trim_valid  = ret.trim_valid || ret.wr_trim;
    if (ret.wr_live) begin
      next_saved_angle = ret.live_angle;
      next_saved_gain  = ret.live_gain;
    end
    if (ret.wr_ref) begin
      next_ref_angle = ret.ref_data;
      next_ref_valid = 1'b1;
    end
    if (ret.wr_thr) begin
      next_threshold = ret.thr_data;
    end
  end

  // stored words are themselves the read registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ret.ref_angle   <= ANGLE_RESET;
      ret.ref_valid   <= 1'b0;
      ret.threshold   <= THRESHOLD_RESET;
      ret.saved_angle <= ANGLE_RESET;
      ret.saved_gain  <= GAIN_RESET;
      ret.trim_valid  <= 1'b0;
    end else begin
      ret.ref_angle   <= next_ref_angle;
      ret.ref_valid   <= next_ref_valid;
      ret.threshold   <= next_threshold;
      ret.saved_angle <= next_saved_angle;
      ret.saved_gain  <= next_saved_gain;
      ret.trim_valid  <= next_trim_valid;
    end
  end
endmodule
`default_nettype wire

// ===== tb/aew_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host side: switches the main supply, sends decoded commands, reads the open-drain wake wire
module aew_host_model #(
  parameter int ON_CYCLES       = 20,  // shortest on-period the host grants
  parameter int FIRST_ON_CYCLES = 200  // continuous on-time before pulsed polling starts
) (
  input  wire logic                        clock,      // system clock
  input  wire logic                        wake_o,     // device wake data
  input  wire logic                        wake_oen,   // device wake enable, low drives
  output logic                             vdd_on,     // switched main supply
  output logic                             cmd_valid,  // command strobe
  output logic      [aew_pkg::CODE_W-1:0]  cmd_code,   // command code
  output logic      [aew_pkg::ANGLE_W-1:0] cmd_data,   // command data byte
  output wire logic                        wake_line   // resolved wake wire
);
  import aew_pkg::*;
  int   on_cnt = 0;    // cycles the supply has been on
  logic cycled = 1'b0; // set once the long initial on-time is over

  // the pull-up wins whenever the device lets go of the pin
  assign wake_line = wake_oen ? 1'b1 : wake_o;

  initial begin
    vdd_on    = 1'b0;
    cmd_valid = 1'b0;
    cmd_code  = 5'h00;
    cmd_data  = 8'h00;
  end

  // on-time counter so the host never cuts a measurement short
  always @(posedge clock) on_cnt <= vdd_on ? on_cnt + 1 : 0;

  // supply switch; the first switch-off waits out the long initial on-time, later ones the
  // minimum on-period; switching off an unpowered chip must not wait for a count that never runs
  task automatic power(input logic on);
    if (!on) begin
      while (vdd_on && (on_cnt < (cycled ? ON_CYCLES : FIRST_ON_CYCLES))) @(posedge clock);
      if (vdd_on) cycled = 1'b1;
    end
    @(posedge clock);
    vdd_on <= on;
  endtask

  // one command per strobe, raised and dropped on rising edges
  task automatic send_cmd(input logic [CODE_W-1:0] code, input logic [ANGLE_W-1:0] data);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_data  <= data;
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import aew_pkg::*;
  localparam int TON = 20;
  logic               clock;
  logic               resetn;
  logic [ANGLE_W-1:0] angle_in;
  logic               conv_locked;
  logic               field_strong;
  logic               field_weak;
  logic               fuse;
  logic [ANGLE_W-1:0] angle_out;
  logic               lock_flag;
  logic [GAIN_W-1:0]  gain;
  logic               low_power;
  logic               trim_valid;
  logic               wake_o;
  logic               wake_oen;
  logic               wake_line;
  logic               vdd_on;
  logic               cmd_valid;
  logic [CODE_W-1:0]  cmd_code;
  logic [ANGLE_W-1:0] cmd_data;
  int                 bad_count;
  int                 cmp_count;
  int                 cycles = 0;

  aew_wake_ctrl #(.TON_CYCLES(TON)) aew_wake_ctrl_i (
    .CLOCK(clock), .RESETN(resetn), .VDD_ON(vdd_on), .CMD_VALID(cmd_valid),
    .CMD_CODE(cmd_code), .CMD_DATA(cmd_data), .ANGLE_IN(angle_in),
    .CONVERTER_LOCKED(conv_locked), .FIELD_STRONG(field_strong), .FIELD_WEAK(field_weak),
    .WAKE_ENABLE_OTP(fuse), .ANGLE_OUT(angle_out), .LOCK_FLAG(lock_flag),
    .GAIN_CONTROL_VALUE(gain), .LOW_POWER(low_power), .TRIM_VALID(trim_valid),
    .WAKE_O(wake_o), .WAKE_OEN(wake_oen)
  );

  aew_host_model #(.ON_CYCLES(TON), .FIRST_ON_CYCLES(10 * TON)) aew_host_model_i (
    .clock(clock), .wake_o(wake_o), .wake_oen(wake_oen), .vdd_on(vdd_on),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .wake_line(wake_line)
  );

  // clock and hang guard; ceiling is several times the expected run
  initial clock = 1'b0;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // power cycle with a given angle; measures delay to the wake edge and its width
  task automatic power_up(input logic [ANGLE_W-1:0] ang, input logic exp_wake);
    int n;
    int m;
    aew_host_model_i.power(1'b0);
    repeat (3) @(posedge clock);
    angle_in <= ang;
    aew_host_model_i.power(1'b1);
    for (n = 0; n < TON + 5; n++) begin
      @(posedge clock);
      #1;
      if (!wake_line) break;
    end
    check("wake delay", 16'(exp_wake ? TON : TON + 5), 16'(n));
    if (!wake_line) begin
      for (m = 1; m < 1100; m++) begin
        @(posedge clock);
        #1;
        if (wake_line) break;
      end
      check("wake width", 16'(WAKE_CYCLES), 16'(m));
    end
  endtask

  task automatic t_reset();
    check("wake enable", 16'h0001, wake_oen);
    check("wake data", 16'h0000, wake_o);
    check("lock", 16'h0000, lock_flag);
    check("gain", 16'h0000, gain);
    check("low power", 16'h0000, low_power);
    check("trim", 16'h0000, trim_valid);
  endtask

  // trim reload code makes trim values valid
  task automatic t_trim();
    aew_host_model_i.send_cmd(CMD_TRIM_RELOAD, 8'h00);
    ticks(2);
    check("trim", 16'h0001, trim_valid);
  endtask

  // low power freezes the angle and drops lock; leaving it restores both
  task automatic t_low_power();
    @(posedge clock);
    conv_locked <= 1'b1;
    angle_in <= 8'h33;
    ticks(3);
    check("lock", 16'h0001, lock_flag);
    aew_host_model_i.send_cmd(CMD_WRITE_CONFIG, 8'h01);
    ticks(3);
    check("low power", 16'h0001, low_power);
    check("lock", 16'h0000, lock_flag);
    @(posedge clock);
    angle_in <= 8'h77;
    ticks(3);
    check("frozen angle", 16'h0033, angle_out);
    aew_host_model_i.send_cmd(CMD_WRITE_CONFIG, 8'h00);
    ticks(TON); // stay active past the scaled wake-up time before trusting the angle
    check("low power", 16'h0000, low_power);
    check("lock", 16'h0001, lock_flag);
    check("angle", 16'h0077, angle_out);
  endtask

  // gain runs into both limits and stays there
  task automatic t_gain();
    @(posedge clock);
    field_weak <= 1'b1;
    ticks(80);
    check("gain high", 16'(GAIN_MAX), gain);
    @(posedge clock);
    field_weak <= 1'b0;
    field_strong <= 1'b1;
    ticks(80);
    check("gain low", 16'(GAIN_MIN), gain);
    @(posedge clock);
    field_strong <= 1'b0;
  endtask

  // reference near zero, threshold 10: distances 10 stay quiet, 11 wake
  task automatic t_compare();
    logic [ANGLE_W-1:0] angs [5];
    logic               hits [5];
    angs = '{8'h04, 8'h05, 8'hf0, 8'hef, 8'hfa};
    hits = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    aew_host_model_i.send_cmd(CMD_PROGRAM_USER_SETTINGS, 8'h0a);
    angle_in <= 8'hfa;
    ticks(2);
    aew_host_model_i.send_cmd(CMD_STORE_REF, 8'h00);
    ticks(2);
    for (int i = 0; i < 5; i++) begin
      power_up(angs[i], hits[i]);
    end
  endtask

  initial begin
    resetn = 1'b0;
    angle_in = 8'h00;
    conv_locked = 1'b0;
    field_strong = 1'b0;
    field_weak = 1'b0;
    fuse = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    ticks(1);
    t_reset();
    power_up(8'h40, 1'b1);
    t_trim();
    t_low_power();
    t_gain();
    t_compare();
    @(posedge clock);
    fuse <= 1'b0;
    power_up(8'h80, 1'b0);
    // a store-reference without the fuse must leave the old reference, so 80 still wakes
    aew_host_model_i.send_cmd(CMD_STORE_REF, 8'h00);
    @(posedge clock);
    fuse <= 1'b1;
    power_up(8'h80, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
